// ---- verilog/dea_regs.svh ----
// constants for the data eeprom access block
`ifndef DEA_REGS_SVH
`define DEA_REGS_SVH

// register selectors on the software write port
`define DEA_SEL_ADDR_LOW   3'h0
`define DEA_SEL_ADDR_HIGH  3'h1
`define DEA_SEL_DATA       3'h2
`define DEA_SEL_CONTROL    3'h3
`define DEA_SEL_UNLOCK     3'h4

// control register bit positions
`define DEA_CTL_PGD_BIT    7
`define DEA_CTL_CONFIG_SPACE_SELECT_BIT   6
`define DEA_CTL_WRITE_ENABLE_LATCH_BIT   2
`define DEA_CTL_WR_BIT     1
`define DEA_CTL_RD_BIT     0

// unlock key bytes
`define DEA_KEY_FIRST      8'h55
`define DEA_KEY_SECOND     8'hAA

// reset values
`define DEA_BYTE_RESET     8'h00

// write cycle timing
`define DEA_CLK_PERIOD_NS  25
`define DEA_WRITE_TIME_NS  2000
`define DEA_WRITE_CYCLES   ((`DEA_WRITE_TIME_NS + `DEA_CLK_PERIOD_NS - 1) / `DEA_CLK_PERIOD_NS)
`define DEA_CNT_W          8
`define DEA_MEM_DEPTH      256

`endif

// ---- verilog/dea_pkg.sv ----
// types for the data eeprom access block
`include "dea_regs.svh"

package dea_pkg;

  // unlock sequence tracker, one-hot
  typedef enum logic [2:0] {
    DEA_SEQ_IDLE  = 3'b001,
    DEA_SEQ_KEY1  = 3'b010,
    DEA_SEQ_ARMED = 3'b100
  } dea_seq_t;

  // state of the access controller
  typedef struct packed {
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] data;
    logic       pgd;
    logic       config_space_select;
    logic       write_enable_latch;
    logic       wr;
    dea_seq_t   seq;
    logic       start;
    logic       flag;
    logic       commit;
  } dea_state_t;

  // state of the write cycle timer
  typedef struct packed {
    logic [`DEA_CNT_W-1:0] cnt;
    logic                  run;
    logic                  done;
  } dea_tmr_state_t;

endpackage

// ---- verilog/dea_tmr_if.sv ----
// link between the access controller and its write cycle timer
`timescale 1ns/1ps

interface dea_tmr_if;
  logic start;
  logic done;

  modport ctrl (output start, input done);
  modport tmr  (input start, output done);
endinterface

// ---- verilog/dea_write_timer.sv ----
// busy period timer for one eeprom write cycle
`timescale 1ns/1ps
`include "dea_regs.svh"

module dea_write_timer (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  dea_tmr_if.tmr    tmr
);

  dea_pkg::dea_tmr_state_t s_q;
  dea_pkg::dea_tmr_state_t s_d;

  // load on start, count down, one done pulse at the end
  always_comb
  begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (tmr.start)
    begin
      s_d.cnt = `DEA_CNT_W'(`DEA_WRITE_CYCLES - 1);
      s_d.run = 1'b1;
    end
    else if (s_q.run)
    begin
      if (s_q.cnt == '0)
      begin
        s_d.run  = 1'b0;
        s_d.done = 1'b1; // R16
      end
      else
      begin
        s_d.cnt = s_q.cnt - `DEA_CNT_W'(1);
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign tmr.done = s_q.done;

endmodule

// ---- verilog/dea_top.sv ----
// data eeprom access controller with unlock-protected writes
// What this block does
// (R1) read strobe loads addressed byte next cycle
// (R2) read byte held until next read/write
// (R3) software sets address and data first
// (R4) write needs 55h, 0AAh, then start bit
// (R5) software masks interrupts around unlock sequence
// (R6) writes accepted only with enable bit set
// (R7) hardware never clears the enable bit
// (R8) software keeps enable clear when idle
// (R9) registers frozen while write is busy
// (R10) start bit blocked while enable is clear
// (R11) enable and start together start nothing
// (R12) completion clears start, sets done flag
// (R13) done flag sticky until software clears
// (R14) software reads back to verify writes
// (R15) both space selects clear target eeprom
// (R16) write is a busy period, one end event
`timescale 1ns/1ps
`include "dea_regs.svh"

module dea_top (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       reg_wr_i,
  input  wire logic [2:0] reg_sel_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       done_flag_clr_i,
  output logic      [7:0] nvm_addr_low_o,
  output logic      [7:0] nvm_addr_high_o,
  output logic      [7:0] nvm_data_reg_o,
  output logic      [7:0] nvm_control_reg_o,
  output logic            nvm_done_flag_o
);

  logic       rst_meta_q;
  logic       rst_n_q;
  logic [7:0] mem_q [`DEA_MEM_DEPTH];
  logic [7:0] mem_rdata;

  dea_pkg::dea_state_t s_q;
  dea_pkg::dea_state_t s_d;

  dea_tmr_if tmr_link ();

  // reset release through two flops
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // write cycle timer
  dea_write_timer u_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_q),
    .tmr     (tmr_link.tmr)
  );

  assign tmr_link.start = s_q.start;

  // the cell is written one edge after the busy period ends; a read on that
  // edge takes the byte from the data register instead of the stale cell
  assign mem_rdata = s_q.commit ? s_q.data : mem_q[s_q.addr_lo]; // R1

  // register writes, unlock tracking, read and completion handling
  always_comb
  begin
    logic sel_ctl;
    logic sel_unl;
    logic sel_alo;
    logic sel_ahi;
    logic sel_dat;
    logic key_first;
    logic key_second;
    logic start_ok;
    logic rd_req;
    logic eeprom_space;
    sel_ctl      = reg_wr_i && (reg_sel_i == `DEA_SEL_CONTROL);
    sel_unl      = reg_wr_i && (reg_sel_i == `DEA_SEL_UNLOCK);
    sel_alo      = reg_wr_i && (reg_sel_i == `DEA_SEL_ADDR_LOW);
    sel_ahi      = reg_wr_i && (reg_sel_i == `DEA_SEL_ADDR_HIGH);
    sel_dat      = reg_wr_i && (reg_sel_i == `DEA_SEL_DATA);
    key_first    = sel_unl && (reg_wdata_i == `DEA_KEY_FIRST);
    key_second   = sel_unl && (reg_wdata_i == `DEA_KEY_SECOND);
    eeprom_space = !reg_wdata_i[`DEA_CTL_PGD_BIT] && !reg_wdata_i[`DEA_CTL_CONFIG_SPACE_SELECT_BIT];
    start_ok     = reg_wdata_i[`DEA_CTL_WR_BIT] && s_q.write_enable_latch && eeprom_space;
    rd_req       = reg_wdata_i[`DEA_CTL_RD_BIT] && eeprom_space;
    s_d          = s_q;
    s_d.start    = 1'b0;
    s_d.commit   = 1'b0;

    if (!s_q.wr)
    begin
      // address and data are only writable while idle
      if (sel_alo)
      begin
        s_d.addr_lo = reg_wdata_i; // R9
      end
      if (sel_ahi)
      begin
        s_d.addr_hi = reg_wdata_i; // R9
      end
      if (sel_dat)
      begin
        s_d.data = reg_wdata_i; // R2
      end

      // unlock sequence: any other write breaks it
      if (reg_wr_i)
      begin
        s_d.seq = dea_pkg::DEA_SEQ_IDLE; // R4
      end
      if (key_first)
      begin
        s_d.seq = dea_pkg::DEA_SEQ_KEY1; // R4
      end
      if (key_second && s_q.seq == dea_pkg::DEA_SEQ_KEY1)
      begin
        s_d.seq = dea_pkg::DEA_SEQ_ARMED; // R4
      end

      if (sel_ctl)
      begin
        // enable bit changes only by software
        s_d.write_enable_latch = reg_wdata_i[`DEA_CTL_WRITE_ENABLE_LATCH_BIT]; // R7
        s_d.pgd  = reg_wdata_i[`DEA_CTL_PGD_BIT];
        s_d.config_space_select = reg_wdata_i[`DEA_CTL_CONFIG_SPACE_SELECT_BIT];
        // start needs armed sequence and enable set beforehand
        case (s_q.seq)
          dea_pkg::DEA_SEQ_ARMED:
          begin
            if (start_ok) // R6 R10 R11 R15
            begin
              s_d.wr    = 1'b1; // R4
              s_d.start = 1'b1; // R16
            end
          end
          dea_pkg::DEA_SEQ_IDLE,
          dea_pkg::DEA_SEQ_KEY1:
          begin
            s_d.wr = 1'b0;
          end
          default:
          begin
            s_d.seq = dea_pkg::DEA_SEQ_IDLE;
          end
        endcase
        // read strobe self-clears, byte lands next cycle
        if (rd_req)
        begin
          s_d.data = mem_rdata; // R1 R2
        end
      end
    end
    else if (tmr_link.done)
    begin
      // end of busy period
      s_d.wr     = 1'b0; // R12
      s_d.commit = 1'b1; // R16
    end

    // sticky completion flag, set wins over clear
    if (done_flag_clr_i)
    begin
      s_d.flag = 1'b0; // R13
    end
    if (s_q.wr && tmr_link.done)
    begin
      s_d.flag = 1'b1; // R12 R13
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      s_q         <= '0;
      s_q.addr_lo <= `DEA_BYTE_RESET;
      s_q.addr_hi <= `DEA_BYTE_RESET;
      s_q.data    <= `DEA_BYTE_RESET;
      s_q.seq     <= dea_pkg::DEA_SEQ_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // cell array, written once the busy period ends
  always_ff @(posedge clk_i)
  begin
    if (s_q.commit)
    begin
      mem_q[s_q.addr_lo] <= s_q.data; // R16
    end
  end

  // outputs straight from the state flops
  assign nvm_addr_low_o    = s_q.addr_lo;
  assign nvm_addr_high_o   = s_q.addr_hi;
  assign nvm_data_reg_o    = s_q.data;
  assign nvm_done_flag_o   = s_q.flag;

  // control readback; unused bits and the self-clearing read strobe read as zero
  always_comb
  begin
    nvm_control_reg_o                    = `DEA_BYTE_RESET;
    nvm_control_reg_o[`DEA_CTL_PGD_BIT]  = s_q.pgd;
    nvm_control_reg_o[`DEA_CTL_CONFIG_SPACE_SELECT_BIT] = s_q.config_space_select;
    nvm_control_reg_o[`DEA_CTL_WRITE_ENABLE_LATCH_BIT] = s_q.write_enable_latch;
    nvm_control_reg_o[`DEA_CTL_WR_BIT]   = s_q.wr;
  end

endmodule

// ---- dv/dea_top_asserts.sv ----
// port assertions for the data eeprom access block
`timescale 1ns/1ps
module dea_top_asserts (
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic       reg_wr_i,
  input wire logic [2:0] reg_sel_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       done_flag_clr_i,
  input wire logic [7:0] nvm_addr_low_o,
  input wire logic [7:0] nvm_addr_high_o,
  input wire logic [7:0] nvm_data_reg_o,
  input wire logic [7:0] nvm_control_reg_o,
  input wire logic       nvm_done_flag_o
);
  logic [7:0] c;
  logic       b;
  // control readback and busy bit
  assign c = nvm_control_reg_o;
  assign b = c[1];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // both keys then a start write, one idle cycle between writes
  sequence s_key;
    reg_wr_i && reg_sel_i == 3'h4 && reg_wdata_i == 8'h55 && !b ##1 !reg_wr_i ##1
    reg_wr_i && reg_sel_i == 3'h4 && reg_wdata_i == 8'hAA && !b ##1 !reg_wr_i ##1
    reg_wr_i && reg_sel_i == 3'h3 && reg_wdata_i == 8'h06 && c[2] && !b;
  endsequence
  a_unlock_starts: assert property (s_key |=> b)
    else $error("no start");
  a_start_needs_en: assert property ($rose(b) |-> $past(c[2] && reg_wr_i))
    else $error("start");
  a_busy_length: assert property ($rose(b) |-> ##81 b ##1 (!b && nvm_done_flag_o))
    else $error("busy");
  a_write_enable_latch_kept: assert property (!(reg_wr_i && reg_sel_i == 3'h3) |=> $stable(c[2]))
    else $error("write_enable_latch");
  a_regs_frozen: assert property (b |=> $stable({nvm_addr_low_o, nvm_addr_high_o, nvm_data_reg_o,
    c[7:2]}))
    else $error("frozen");
  a_flag_sticky: assert property (nvm_done_flag_o && !done_flag_clr_i |=> nvm_done_flag_o)
    else $error("sticky");
  a_flag_clear: assert property (done_flag_clr_i |=> !nvm_done_flag_o || $fell(b))
    else $error("clear");
  a_data_cause: assert property (!$stable(nvm_data_reg_o) |-> $past(reg_wr_i && !b))
    else $error("data");
endmodule

// ---- dv/testbench.sv ----
// self-checking bench for the data eeprom access block
`timescale 1ns/1ps
module testbench;
  logic       clk_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic       reg_wr_i = 1'b0;
  logic [2:0] reg_sel_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       done_flag_clr_i = 1'b0;
  logic [7:0] alo, ahi, dat, ctl;
  logic       flg;
  int         bad_count = 0;
  int         samples_checked = 0;
  int         n;
  dea_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .reg_wr_i(reg_wr_i), .reg_sel_i(reg_sel_i),
    .reg_wdata_i(reg_wdata_i), .done_flag_clr_i(done_flag_clr_i), .nvm_addr_low_o(alo),
    .nvm_addr_high_o(ahi), .nvm_data_reg_o(dat), .nvm_control_reg_o(ctl),
    .nvm_done_flag_o(flg));
  // 25 ns clock
  always #12.5 clk_i = ~clk_i;
  // one register write, ends settled at the falling edge
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_sel_i   <= s;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(negedge clk_i);
  endtask
  // two unlock writes then enable plus start
  task automatic go(input logic [7:0] k1, input logic [7:0] k2);
    wr(3'h4, k1);
    wr(3'h4, k2);
    wr(3'h3, 8'h06);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic finish_test;
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // hang guard
  initial
  begin
    #(25 * 2000);
    bad_count++;
    finish_test();
  end
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    wr(3'h0, 8'h10);
    wr(3'h1, 8'h5A);
    wr(3'h2, 8'h3C);
    chk("ahi", 8'h5A, ahi);
    wr(3'h3, 8'h00);
    go(8'h55, 8'hAA);
    chk("ctl", 8'h04, ctl);
    wr(3'h3, 8'h06);
    chk("ctl", 8'h04, ctl);
    go(8'hAA, 8'h55);
    chk("ctl", 8'h04, ctl);
    go(8'h55, 8'h55);
    chk("ctl", 8'h04, ctl);
    go(8'h55, 8'hAA);
    chk("ctl", 8'h06, ctl);
    wr(3'h0, 8'hFF);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h80);
    chk("alo", 8'h10, alo);
    chk("dat", 8'h3C, dat);
    chk("ctl", 8'h06, ctl);
    n = 6;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (ctl[1] === 1'b1 && n < 300);
    chk("busy", 8'h52, n[7:0]);
    chk("ctl", 8'h04, ctl);
    repeat (3) @(negedge clk_i);
    chk("flg", 8'h01, {7'h00, flg});
    @(posedge clk_i);
    done_flag_clr_i <= 1'b1;
    @(posedge clk_i);
    done_flag_clr_i <= 1'b0;
    @(negedge clk_i);
    chk("flg", 8'h00, {7'h00, flg});
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h01);
    chk("ctl", 8'h00, ctl);
    chk("dat", 8'h3C, dat);
    wr(3'h0, 8'h11);
    chk("dat", 8'h3C, dat);
    wr(3'h2, 8'h77);
    wr(3'h3, 8'h41);
    chk("dat", 8'h77, dat);
    finish_test();
  end
endmodule
bind dea_top dea_top_asserts u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .reg_wr_i(reg_wr_i),
  .reg_sel_i(reg_sel_i), .reg_wdata_i(reg_wdata_i), .done_flag_clr_i(done_flag_clr_i),
  .nvm_addr_low_o(nvm_addr_low_o), .nvm_addr_high_o(nvm_addr_high_o),
  .nvm_data_reg_o(nvm_data_reg_o), .nvm_control_reg_o(nvm_control_reg_o),
  .nvm_done_flag_o(nvm_done_flag_o));
